// ---- design/eti_trigger_select.sv ----
// Purpose: Trigger mode and valid edge selection for external interrupt pins
// Assumes: Pins are asynchronous; software follows the programming order below
// Notes: Request flags set wins over acknowledge and software clear
// What this block does
// - Pair pins decode falling, rising, low level, both
// - Low level sampled once every four clocks
// - Acknowledge clears flag; held low re-sets it
// - Level request stays pending until acknowledge or software clear
// - Late port mode write may raise request
// - Sixteen wide pins, bit n to pin n
// - Wide select registers accessed as 16 bits
// - Wide halves writable as separate bytes
// - Timer fields: 7:6 count, 3:2, 1:0
// - Timer field 10 is prohibited, detects nothing
// - Timer edge registers accessed as whole bytes
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
module eti_trigger_select #(
	parameter int AW = 14
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire eti_pkg::eti_pins_t pins_i,
	input wire logic [eti_pkg::NFLAG-1:0] irq_ack_i,
	output logic [eti_pkg::NFLAG-1:0] req_flags_o,
	output logic [eti_pkg::NTMR-1:0] count_tick_o,
	output logic irq_o
);
	initial begin
		if (AW < eti_pkg::IDXW + 2) begin
			$error("AW too small for register index decode");
		end
	end

	function automatic logic trig_hit(input logic [1:0] m, input logic lvl_ok, input logic cur,
		input logic prv, input logic tk);
		logic r;
		r = 1'b0;
		case (m)
			eti_pkg::ETI_TRG_FALL: r = prv & ~cur;
			eti_pkg::ETI_TRG_RISE: r = ~prv & cur;
			eti_pkg::ETI_TRG_LEVEL: r = lvl_ok & tk & ~cur;
			eti_pkg::ETI_TRG_BOTH: r = prv ^ cur;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic [31:0] byte_mask(input logic [3:0] sel);
		return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	logic [1:0] pfall_r, pfall_nxt, prise_r, prise_nxt;
	logic [15:0] wfall_r, wfall_nxt, wrise_r, wrise_nxt;
	logic [7:0] tsel_r [eti_pkg::NTMR];
	logic [7:0] tsel_nxt [eti_pkg::NTMR];
	logic [eti_pkg::NFLAG-1:0] st_r, st_nxt, mask_r, mask_nxt, set_v;
	logic [eti_pkg::NPMC-1:0] pmc_r, pmc_nxt;
	logic [eti_pkg::NPIN-1:0] s1_r, s2_r, eff_r, prev_r;
	logic [1:0] div_r;
	logic ack_r;
	logic [31:0] dat_r;
	logic [eti_pkg::NTMR-1:0] cnt_r;
	logic irq_r;

	wire logic [eti_pkg::NPIN-1:0] pin_w = pins_i;
	wire logic req_w = wb_cyc_i & wb_stb_i;
	wire logic wr_w = req_w & wb_we_i & ack_r;
	wire logic [11:0] idx_w = wb_adr_i[eti_pkg::IDXW+1:2];
	wire logic [31:0] bm_w = byte_mask(wb_sel_i);
	wire logic [31:0] wd_w = wb_dat_i & bm_w;
	wire logic hit_pf = idx_w == eti_pkg::IDX_PAIR_FALL;
	wire logic hit_pr = idx_w == eti_pkg::IDX_PAIR_RISE;
	wire logic hit_wf = idx_w == eti_pkg::IDX_WIDE_FALL;
	wire logic hit_wr = idx_w == eti_pkg::IDX_WIDE_RISE;
	wire logic hit_st = idx_w == eti_pkg::IDX_STATUS;
	wire logic hit_mk = idx_w == eti_pkg::IDX_MASK;
	wire logic hit_pm = idx_w == eti_pkg::IDX_PMC;
	wire logic [eti_pkg::NTMR-1:0] hit_t = {idx_w == eti_pkg::IDX_TMR3, idx_w == eti_pkg::IDX_TMR2,
		idx_w == eti_pkg::IDX_TMR1, idx_w == eti_pkg::IDX_TMR0};
	wire logic tick_w = div_r == eti_pkg::LVL_LAST;
	// Port mode off holds the pin at its idle high level, so enabling it over a low pin looks like a falling edge
	wire logic [eti_pkg::NPIN-1:0] gate_w = {pmc_r[21:18], pmc_r[21:18], pmc_r[17:0]};
	wire logic [eti_pkg::NFLAG-1:0] clr_w = (wr_w && hit_st) ? wd_w[eti_pkg::NFLAG-1:0] : '0;

	// Halves of the wide registers follow their byte lanes; single bits are read-modify-write
	assign pfall_nxt = (wr_w && hit_pf && wb_sel_i[0]) ? wb_dat_i[1:0] : pfall_r;
	assign prise_nxt = (wr_w && hit_pr && wb_sel_i[0]) ? wb_dat_i[1:0] : prise_r;
	assign wfall_nxt = (wr_w && hit_wf) ? ((wfall_r & ~bm_w[15:0]) | wd_w[15:0]) : wfall_r;
	assign wrise_nxt = (wr_w && hit_wr) ? ((wrise_r & ~bm_w[15:0]) | wd_w[15:0]) : wrise_r;
	assign mask_nxt = (wr_w && hit_mk) ? ((mask_r & ~bm_w[29:0]) | wd_w[29:0]) : mask_r;
	assign pmc_nxt = (wr_w && hit_pm) ? ((pmc_r & ~bm_w[21:0]) | wd_w[21:0]) : pmc_r;
	// Set wins over acknowledge and software clear, so a held low level repeats
	assign st_nxt = (st_r & ~clr_w & ~irq_ack_i) | set_v;

	always_comb begin
		for (int t = 0; t < eti_pkg::NTMR; t++) begin
			tsel_nxt[t] = (wr_w && hit_t[t] && wb_sel_i[0]) ? wb_dat_i[7:0] : tsel_r[t];
		end
	end

	// Flags come only from sampled pin history, never from the select bits changing
	always_comb begin
		set_v = '0;
		for (int i = 0; i < eti_pkg::NPAIR; i++) begin
			set_v[eti_pkg::POS_PAIR+i] = trig_hit({pfall_r[i], prise_r[i]}, 1'b1, eff_r[eti_pkg::POS_PAIR+i],
				prev_r[eti_pkg::POS_PAIR+i], tick_w);
		end
		for (int i = 0; i < eti_pkg::NWIDE; i++) begin
			set_v[eti_pkg::POS_WIDE+i] = trig_hit({wfall_r[i], wrise_r[i]}, 1'b1, eff_r[eti_pkg::POS_WIDE+i],
				prev_r[eti_pkg::POS_WIDE+i], tick_w);
		end
		for (int t = 0; t < eti_pkg::NTMR; t++) begin
			set_v[eti_pkg::POS_CAPA+t] = trig_hit(tsel_r[t][eti_pkg::TF_CAPA+:2], 1'b0,
				eff_r[eti_pkg::POS_CAPA+t], prev_r[eti_pkg::POS_CAPA+t], tick_w);
			set_v[eti_pkg::POS_CAPB+t] = trig_hit(tsel_r[t][eti_pkg::TF_CAPB+:2], 1'b0,
				eff_r[eti_pkg::POS_CAPB+t], prev_r[eti_pkg::POS_CAPB+t], tick_w);
			set_v[eti_pkg::POS_CNT+t] = trig_hit(tsel_r[t][eti_pkg::TF_CNT+:2], 1'b0,
				eff_r[eti_pkg::POS_CAPA+t], prev_r[eti_pkg::POS_CAPA+t], tick_w);
		end
	end

	wire logic [31:0] rd_w = hit_pf ? {30'h0, pfall_r} :
		hit_pr ? {30'h0, prise_r} :
		hit_wf ? {16'h0, wfall_r} :
		hit_wr ? {16'h0, wrise_r} :
		hit_t[0] ? {24'h0, tsel_r[0]} :
		hit_t[1] ? {24'h0, tsel_r[1]} :
		hit_t[2] ? {24'h0, tsel_r[2]} :
		hit_t[3] ? {24'h0, tsel_r[3]} :
		hit_st ? {2'h0, st_r} :
		hit_mk ? {2'h0, mask_r} :
		hit_pm ? {10'h0, pmc_r} : 32'h0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0;
		end else begin
			ack_r <= req_w & ~ack_r;
			dat_r <= (req_w && !ack_r) ? rd_w : dat_r;
		end
	end

	// Only s2 reads s1; the gated copy and its history feed the detectors
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_r <= '1;
			s2_r <= '1;
			eff_r <= '1;
			prev_r <= '1;
			div_r <= 2'h0;
		end else begin
			s1_r <= pin_w;
			s2_r <= s1_r;
			eff_r <= s2_r | ~gate_w;
			prev_r <= eff_r;
			div_r <= div_r + 2'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pfall_r <= eti_pkg::RST_PAIR_FALL;
			prise_r <= eti_pkg::RST_PAIR_RISE;
			wfall_r <= eti_pkg::RST_WIDE_FALL;
			wrise_r <= eti_pkg::RST_WIDE_RISE;
			mask_r <= '0;
			pmc_r <= '0;
		end else begin
			pfall_r <= pfall_nxt;
			prise_r <= prise_nxt;
			wfall_r <= wfall_nxt;
			wrise_r <= wrise_nxt;
			mask_r <= mask_nxt;
			pmc_r <= pmc_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		for (int t = 0; t < eti_pkg::NTMR; t++) begin
			tsel_r[t] <= rst_i ? eti_pkg::RST_TMR : tsel_nxt[t];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
			cnt_r <= '0;
			irq_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= set_v[eti_pkg::POS_CNT+:eti_pkg::NTMR];
			irq_r <= |(st_nxt & mask_nxt);
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign req_flags_o = st_r;
	assign count_tick_o = cnt_r;
	assign irq_o = irq_r;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_pair_fall;
		(pfall_r[0] == 1'b0 && prise_r[0] == 1'b0 && prev_r[0] && !eff_r[0]) |=> st_r[0];
	endproperty
	a_pair_fall: assert property (p_pair_fall) else $error("falling edge on pair pin 0 not flagged");

	property p_pair_rise_quiet;
		(pfall_r[0] == 1'b0 && prise_r[0] && !(eff_r[0] && !prev_r[0])) |-> !set_v[0];
	endproperty
	a_pair_rise_quiet: assert property (p_pair_rise_quiet) else $error("rising mode set without rise");

	property p_level_tick;
		(pfall_r[1] && !prise_r[1] && set_v[1]) |-> (div_r == 2'h3 && !eff_r[1]);
	endproperty
	a_level_tick: assert property (p_level_tick) else $error("level request off the sampling tick");

	property p_level_repeat;
		(pfall_r[0] && !prise_r[0] && !eff_r[0] && tick_w && irq_ack_i[0]) |=> st_r[0];
	endproperty
	a_level_repeat: assert property (p_level_repeat) else $error("held low level did not re-set flag");

	property p_ack_clear;
		(irq_ack_i[0] && !set_v[0]) |=> !st_r[0];
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("acknowledge did not clear flag");

	property p_pending_held;
		(st_r[0] && !irq_ack_i[0] && !(wr_w && hit_st && wb_sel_i[0] && wb_dat_i[0])) |=> st_r[0];
	endproperty
	a_pending_held: assert property (p_pending_held) else $error("pending flag lost");

	property p_tmr_prohibited;
		(tsel_r[1][3:2] == 2'b10) |-> !set_v[eti_pkg::POS_CAPB+1];
	endproperty
	a_tmr_prohibited: assert property (p_tmr_prohibited) else $error("prohibited timer setting detected");

	property p_tmr_byte_only;
		(wr_w && hit_t[1] && !wb_sel_i[0]) |=> tsel_r[1] == $past(tsel_r[1]);
	endproperty
	a_tmr_byte_only: assert property (p_tmr_byte_only) else $error("timer select changed without byte 0");

	property p_wide_half;
		(wr_w && hit_wf && wb_sel_i[1:0] == 2'b01) |=> (wfall_r[15:8] == $past(wfall_r[15:8])
			&& wfall_r[7:0] == $past(wb_dat_i[7:0]));
	endproperty
	a_wide_half: assert property (p_wide_half) else $error("wide lower byte write disturbed upper");

	property p_cfg_quiet;
		(prev_r[0] == eff_r[0] && !pfall_r[0]) |-> !set_v[0];
	endproperty
	a_cfg_quiet: assert property (p_cfg_quiet) else $error("request without pin activity");

	property p_irq;
		((st_r & mask_r) != '0) |-> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("unmasked flag without interrupt");

	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

	property p_wide_both;
		({wfall_r[15], wrise_r[15]} == 2'b11 && prev_r[17] != eff_r[17]) |=> st_r[17];
	endproperty
	a_wide_both: assert property (p_wide_both) else $error("wide pin 15 edge not flagged");

	property p_wide_rise;
		({wfall_r[14], wrise_r[14]} == 2'b01 && !prev_r[16] && eff_r[16]) |=> st_r[16];
	endproperty
	a_wide_rise: assert property (p_wide_rise) else $error("wide pin 14 rise not flagged");

	property p_wide_word;
		(wr_w && hit_wf && wb_sel_i[1:0] == 2'b11) |=> (wfall_r == $past(wb_dat_i[15:0]));
	endproperty
	a_wide_word: assert property (p_wide_word) else $error("wide word write not stored");

	property p_wide_quiet;
		(prev_r[16] == eff_r[16] && !(wfall_r[14] && !wrise_r[14])) |-> !set_v[16];
	endproperty
	a_wide_quiet: assert property (p_wide_quiet) else $error("wide request without pin edge");

	property p_tmr_count;
		(tsel_r[1][7:6] == 2'b11 && prev_r[eti_pkg::POS_CAPA+1] != eff_r[eti_pkg::POS_CAPA+1]) |=> count_tick_o[1];
	endproperty
	a_tmr_count: assert property (p_tmr_count) else $error("count input edge gave no tick");

	property p_tmr_cap_rise;
		(tsel_r[1][1:0] == 2'b01 && !prev_r[eti_pkg::POS_CAPA+1] && eff_r[eti_pkg::POS_CAPA+1])
			|=> st_r[eti_pkg::POS_CAPA+1];
	endproperty
	a_tmr_cap_rise: assert property (p_tmr_cap_rise) else $error("capture rise not flagged");

	property p_tmr_cnt_quiet;
		(tsel_r[1][7:6] == 2'b11 && prev_r[eti_pkg::POS_CAPA+1] == eff_r[eti_pkg::POS_CAPA+1])
			|-> !set_v[eti_pkg::POS_CNT+1];
	endproperty
	a_tmr_cnt_quiet: assert property (p_tmr_cnt_quiet) else $error("count event without edge");

	property p_gate_idle;
		!pmc_r[0] |=> eff_r[0];
	endproperty
	a_gate_idle: assert property (p_gate_idle) else $error("gated pin not held idle");

	property p_sync;
		pmc_r[0] |=> (eff_r[0] == $past(s2_r[0]));
	endproperty
	a_sync: assert property (p_sync) else $error("pin history skipped a stage");

	property p_w1c;
		(st_r[1] && wr_w && hit_st && wb_sel_i[0] && wb_dat_i[1] && !set_v[1]) |=> !st_r[1];
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

	property p_mask_gate;
		((st_r & mask_r) == '0) |-> !irq_o;
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("interrupt without unmasked flag");

	property p_ack_answer;
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged next cycle");

	property p_rd_data;
		(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && hit_pr) |=> (wb_dat_o == {30'h0, $past(prise_r)});
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("pair rise read data wrong");

	property p_level_ignore;
		({pfall_r[0], prise_r[0]} == 2'b10 && !tick_w) |-> !set_v[0];
	endproperty
	a_level_ignore: assert property (p_level_ignore) else $error("level request between ticks");

	property p_pair_rise1;
		({pfall_r[1], prise_r[1]} == 2'b01 && !prev_r[1] && eff_r[1]) |=> st_r[1];
	endproperty
	a_pair_rise1: assert property (p_pair_rise1) else $error("rise on pair pin 1 not flagged");

	property p_pair_both;
		({pfall_r[0], prise_r[0]} == 2'b11 && prev_r[0] && !eff_r[0]) |=> st_r[0];
	endproperty
	a_pair_both: assert property (p_pair_both) else $error("both mode fall not flagged");

	property p_pair_quiet_fall;
		({pfall_r[0], prise_r[0]} == 2'b00 && !(prev_r[0] && !eff_r[0])) |-> !set_v[0];
	endproperty
	a_pair_quiet_fall: assert property (p_pair_quiet_fall) else $error("falling mode set without fall");

	c_level_repeat: cover property (pfall_r[0] && !prise_r[0] && irq_ack_i[0] && set_v[0]);
	c_both_edges: cover property (wfall_r[5] && wrise_r[5] && set_v[eti_pkg::POS_WIDE+5]);
	c_count_tick: cover property (count_tick_o[2]);
	c_irq: cover property (irq_o);
	c_port_gated: cover property (!pmc_r[0] && !s2_r[0]);
endmodule

// ---- design/eti_pkg.sv ----
// Purpose: Constants and types for the external trigger select block
// Assumes: 32-bit classic Wishbone, one word per register index
// Notes: Byte address of a register is four times its index
package eti_pkg;
	localparam int NPAIR = 2;
	localparam int NWIDE = 16;
	localparam int NTMR = 4;
	localparam int NPIN = 26;
	localparam int NFLAG = 30;
	localparam int NPMC = 22;
	localparam int LVL_DIV = 4;
	localparam logic [1:0] LVL_LAST = 2'(LVL_DIV - 1);
	localparam logic [31:0] OFS_PAIR_FALL = 32'h0FFFFC10;
	localparam logic [31:0] OFS_TMR0 = 32'hFFFFF609;
	localparam logic [31:0] OFS_TMR1 = 32'hFFFFF629;
	localparam logic [31:0] OFS_TMR2 = 32'hFFFFF649;
	localparam logic [31:0] OFS_TMR3 = 32'hFFFFF669;
	localparam logic [31:0] OFS_WIDE_FALL = 32'hFFFFFC16;
	localparam logic [31:0] OFS_PAIR_RISE = 32'hFFFFFC30;
	localparam logic [31:0] OFS_WIDE_RISE = 32'hFFFFFC36;
	localparam logic [31:0] OFS_STATUS = 32'h00000100;
	localparam logic [31:0] OFS_MASK = 32'h00000101;
	localparam logic [31:0] OFS_PMC = 32'h00000102;
	localparam int IDXW = 12;
	localparam logic [11:0] IDX_PAIR_FALL = OFS_PAIR_FALL[11:0];
	localparam logic [11:0] IDX_TMR0 = OFS_TMR0[11:0];
	localparam logic [11:0] IDX_TMR1 = OFS_TMR1[11:0];
	localparam logic [11:0] IDX_TMR2 = OFS_TMR2[11:0];
	localparam logic [11:0] IDX_TMR3 = OFS_TMR3[11:0];
	localparam logic [11:0] IDX_WIDE_FALL = OFS_WIDE_FALL[11:0];
	localparam logic [11:0] IDX_PAIR_RISE = OFS_PAIR_RISE[11:0];
	localparam logic [11:0] IDX_WIDE_RISE = OFS_WIDE_RISE[11:0];
	localparam logic [11:0] IDX_STATUS = OFS_STATUS[11:0];
	localparam logic [11:0] IDX_MASK = OFS_MASK[11:0];
	localparam logic [11:0] IDX_PMC = OFS_PMC[11:0];
	localparam logic [1:0] RST_PAIR_FALL = 2'h0;
	localparam logic [1:0] RST_PAIR_RISE = 2'h3;
	localparam logic [15:0] RST_WIDE_FALL = 16'h0000;
	localparam logic [15:0] RST_WIDE_RISE = 16'hFFFF;
	localparam logic [7:0] RST_TMR = 8'h00;
	localparam int POS_PAIR = 0;
	localparam int POS_WIDE = 2;
	localparam int POS_CAPA = 18;
	localparam int POS_CAPB = 22;
	localparam int POS_CNT = 26;
	localparam int PMC_TMR = 18;
	localparam int TF_CAPA = 0;
	localparam int TF_CAPB = 2;
	localparam int TF_CNT = 6;
	typedef enum logic [1:0] {
		ETI_TRG_FALL = 2'b00,
		ETI_TRG_RISE = 2'b01,
		ETI_TRG_LEVEL = 2'b10,
		ETI_TRG_BOTH = 2'b11
	} eti_trig_t;
	typedef struct packed {
		logic [3:0] cap_b;
		logic [3:0] cap_a;
		logic [15:0] wide;
		logic [1:0] pair;
	} eti_pins_t;
endpackage

// ---- verification/eti_pin_model.sv ----
// Purpose: External devices that drive the interrupt and timer input pins
// Assumes: Pins idle high; callers hold each level for several clocks
// Notes: Changes land on a rising edge so the synchroniser sees a clean level
`timescale 1ns/1ps
module eti_pin_model (
	input wire logic clk_i,
	output eti_pkg::eti_pins_t pins_o
);
	initial pins_o = '1;
	// A pin is never pulsed for a single clock: shorter pulses may be missed
	task automatic drive(input int idx, input logic v);
		@(posedge clk_i);
		pins_o[idx] <= v;
	endtask
endmodule

// ---- verification/eti_trigger_select_bench.sv ----
// Purpose: Self-checking bench for the trigger select block
// Assumes: Classic Wishbone master, one clock, status read back over the bus except in t_irq, which samples req_flags_o
// Notes: Each scenario is one task; pins come from the partner model
`timescale 1ns/1ps
module eti_trigger_select_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [13:0] adr = 14'h0000;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	eti_pkg::eti_pins_t pins;
	logic [29:0] irq_ack = 30'h00000000;
	logic [29:0] req_flags_o;
	logic [3:0] count_tick_o;
	logic irq_o;
	int error_cnt = 0;
	int check_count = 0;
	int tick_cnt = 0;
	always #50 clk_i = ~clk_i;
	eti_trigger_select #(.AW(14)) i_eti_trigger_select (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .pins_i(pins), .irq_ack_i(irq_ack), .req_flags_o(req_flags_o),
		.count_tick_o(count_tick_o), .irq_o(irq_o));
	eti_pin_model i_eti_pin_model (.clk_i(clk_i), .pins_o(pins));
	always @(posedge clk_i) if (count_tick_o[1] === 1'b1) tick_cnt <= tick_cnt + 1;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [11:0] ix, input logic [3:0] s, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {ix, 2'b00};
		sel <= s;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk(32'(n), 32'h00000002);
	endtask
	task automatic wr(input logic [11:0] ix, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, ix, 4'hF, d, q);
	endtask
	task automatic rd(input logic [11:0] ix, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, ix, 4'hF, 32'h00000000, q);
		chk(q, e);
	endtask
	task automatic rs(input logic [31:0] e);
		rd(eti_pkg::IDX_STATUS, e);
	endtask
	task automatic clr;
		wr(eti_pkg::IDX_STATUS, 32'h3FFFFFFF);
	endtask
	task automatic t_reset;
		rd(eti_pkg::IDX_PAIR_FALL, {30'h0, eti_pkg::RST_PAIR_FALL});
		rd(eti_pkg::IDX_PAIR_RISE, {30'h0, eti_pkg::RST_PAIR_RISE});
		rd(eti_pkg::IDX_WIDE_FALL, {16'h0, eti_pkg::RST_WIDE_FALL});
		rd(eti_pkg::IDX_WIDE_RISE, {16'h0, eti_pkg::RST_WIDE_RISE});
		rd(eti_pkg::IDX_TMR0, {24'h0, eti_pkg::RST_TMR});
		rd(eti_pkg::IDX_TMR3, {24'h0, eti_pkg::RST_TMR});
		rd(eti_pkg::IDX_MASK, 32'h00000000);
		rd(12'h7FF, 32'h00000000);
		rs(32'h00000000);
		wr(eti_pkg::IDX_PMC, 32'h003FFFFF);
		$display("test reset values done");
	endtask
	task automatic t_pair_modes;
		logic [1:0] m;
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			wr(eti_pkg::IDX_PAIR_FALL, {31'h0, m[1]});
			wr(eti_pkg::IDX_PAIR_RISE, {30'h0, 1'b1, m[0]});
			rs(32'h00000000);
			i_eti_pin_model.drive(0, 1'b0);
			repeat (8) @(posedge clk_i);
			rs({31'h0, m != 2'h1});
			@(posedge clk_i);
			irq_ack <= 30'h00000001;
			@(posedge clk_i);
			irq_ack <= 30'h00000000;
			repeat (8) @(posedge clk_i);
			rs({31'h0, m == 2'h2});
			i_eti_pin_model.drive(0, 1'b1);
			repeat (8) @(posedge clk_i);
			rs({31'h0, m != 2'h0});
			clr();
			repeat (8) @(posedge clk_i);
			rs(32'h00000000);
		end
		$display("test pair modes done");
	endtask
	task automatic t_port_mode;
		wr(eti_pkg::IDX_PAIR_FALL, 32'h00000000);
		wr(eti_pkg::IDX_PAIR_RISE, 32'h00000002);
		wr(eti_pkg::IDX_PMC, 32'h003FFFFE);
		i_eti_pin_model.drive(0, 1'b0);
		repeat (8) @(posedge clk_i);
		rs(32'h00000000);
		wr(eti_pkg::IDX_PMC, 32'h003FFFFF);
		repeat (8) @(posedge clk_i);
		rs(32'h00000001);
		i_eti_pin_model.drive(0, 1'b1);
		repeat (8) @(posedge clk_i);
		clr();
		$display("test port mode done");
	endtask
	task automatic t_wide;
		logic [31:0] q;
		wb(1'b1, eti_pkg::IDX_WIDE_FALL, 4'h2, 32'h0000A5FF, q);
		wb(1'b1, eti_pkg::IDX_WIDE_FALL, 4'h1, 32'h0000FF5A, q);
		rd(eti_pkg::IDX_WIDE_FALL, 32'h0000A55A);
		wb(1'b1, eti_pkg::IDX_WIDE_FALL, 4'h3, 32'h00008000, q);
		rd(eti_pkg::IDX_WIDE_FALL, 32'h00008000);
		rs(32'h00000000);
		i_eti_pin_model.drive(17, 1'b0);
		i_eti_pin_model.drive(16, 1'b0);
		repeat (8) @(posedge clk_i);
		rs(32'h00020000);
		clr();
		i_eti_pin_model.drive(17, 1'b1);
		i_eti_pin_model.drive(16, 1'b1);
		repeat (8) @(posedge clk_i);
		rs(32'h00030000);
		clr();
		$display("test wide group done");
	endtask
	task automatic t_timer;
		logic [31:0] q;
		wb(1'b1, eti_pkg::IDX_TMR1, 4'h1, 32'h000000C9, q);
		wb(1'b1, eti_pkg::IDX_TMR1, 4'h2, 32'h0000FF00, q);
		rd(eti_pkg::IDX_TMR1, 32'h000000C9);
		i_eti_pin_model.drive(19, 1'b0);
		i_eti_pin_model.drive(23, 1'b0);
		repeat (8) @(posedge clk_i);
		rs(32'h08000000);
		clr();
		i_eti_pin_model.drive(19, 1'b1);
		i_eti_pin_model.drive(23, 1'b1);
		repeat (8) @(posedge clk_i);
		rs(32'h08080000);
		chk(32'(tick_cnt), 32'h00000002);
		clr();
		$display("test timer edges done");
	endtask
	task automatic t_irq;
		i_eti_pin_model.drive(1, 1'b0);
		repeat (4) @(posedge clk_i);
		i_eti_pin_model.drive(1, 1'b1);
		repeat (8) @(posedge clk_i);
		chk(32'(req_flags_o), 32'h00000002);
		chk({31'h0, irq_o}, 32'h00000000);
		wr(eti_pkg::IDX_MASK, 32'h00000002);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h00000001);
		wr(eti_pkg::IDX_STATUS, 32'h00000002);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h00000000);
		$display("test interrupt done");
	endtask
	task automatic wrap_up;
		$display("TB: checks=%0d mismatches=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Ten thousand clocks is several times what the scenarios need
	initial begin
		#1000000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_pair_modes();
		t_port_mode();
		t_wide();
		t_timer();
		t_irq();
		wrap_up();
	end
endmodule
